// *** inc/fosp_pkg.sv ***
// Package: constants and types for the flash status polling host controller
package fosp_pkg;

    // ------------------------------------------------------------------
    // Register map of the controller (Wishbone, byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_LAST = 8'h10;

    // Control fields (write 1 to start; bit 4 is reserved and starts nothing)
    localparam int CTRL_POLL = 0;
    localparam int CTRL_TOGGLE = 1;
    localparam int CTRL_RST1 = 2;
    localparam int CTRL_RST3 = 3;
    localparam int CTRL_POLARITY_RSVD = 4;

    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_FAIL = 2;
    localparam int STAT_ABORT = 3;
    localparam int STAT_RDYPIN = 4;

    // Polled status bit positions
    localparam int COMPLETION_POLARITY_BIT = 7;
    localparam int PRIMARY_TOGGLE_BIT = 6;
    localparam int OPERATION_ERROR_BIT = 5;
    localparam int ERASE_STARTED_BIT = 3;
    localparam int ERASE_BLOCK_TOGGLE_BIT = 2;
    localparam int BUFFER_ABORT_BIT = 1;

    // Reset command data and unlock addresses
    localparam logic [15:0] CMD_AA = 16'h00aa;
    localparam logic [15:0] CMD_55 = 16'h0055;
    localparam logic [15:0] CMD_F0 = 16'h00f0;
    localparam logic [25:0] ADR_555 = 26'h0000555;
    localparam logic [25:0] ADR_2AA = 26'h00002aa;

    // ------------------------------------------------------------------
    // Timing (bus cycle phase lengths)
    // ------------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int ACC_NS = 110;
    localparam int WP_NS = 50;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ACC_CNT = 4'(ACC_CYC);
    localparam logic [3:0] WP_CNT = 4'(WP_CYC);

    // Flash pin group driven by the controller
    typedef struct packed {
        logic [25:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic ce_b;
        logic oe_b;
        logic we_b;
    } fosp_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_RD = 7'b0000010,
        ST_EVAL = 7'b0000100,
        ST_WR = 7'b0001000,
        ST_GAP = 7'b0010000,
        ST_NEXT = 7'b0100000,
        ST_END = 7'b1000000
    } fosp_state_t;

endpackage

// *** hdl/fosp_host.sv ***
// Host controller that polls flash operation progress and issues recovery
`timescale 1ns/100ps

module fosp_host
    import fosp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output fosp_pins_t pins_o,
    input wire logic [15:0] dq_i,
    input wire logic busy_output_pin_i
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    fosp_state_t st_ff, nxt_st;
    fosp_pins_t pins_ff, nxt_pins;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [1:0] step_ff, nxt_step;
    logic [1:0] mode_ff, nxt_mode; // 0 poll,1 toggle,2 reset1,3 reset3
    logic [25:0] adr_ff, nxt_adr;
    logic [7:0] exp_ff, nxt_exp;
    logic [15:0] last_ff, nxt_last;
    logic [15:0] prev_ff, nxt_prev;
    logic havep_ff, nxt_havep;
    logic quiet_ff, nxt_quiet;
    logic errseen_ff, nxt_errseen;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic fail_ff, nxt_fail;
    logic abort_ff, nxt_abort;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [15:0] dq_s1_ff, dq_s2_ff;
    logic rb_s1_ff, rb_s2_ff;
    logic wb_req;
    logic wr_ctrl;
    logic [7:0] sts;
    logic toggled;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
            rb_s1_ff <= 1'b1;
            rb_s2_ff <= 1'b1;
        end else begin
            dq_s1_ff <= dq_i;
            dq_s2_ff <= dq_s1_ff;
            rb_s1_ff <= busy_output_pin_i;
            rb_s2_ff <= rb_s1_ff;
        end
    end

    // Request decode; ack given one cycle after the request
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == REG_CTRL) && !busy_ff;
    assign sts = dq_s2_ff[7:0];
    assign toggled = havep_ff &&
                     (sts[PRIMARY_TOGGLE_BIT] !=
                      prev_ff[PRIMARY_TOGGLE_BIT]);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_pins = pins_ff;
        nxt_cnt = cnt_ff;
        nxt_step = step_ff;
        nxt_mode = mode_ff;
        nxt_adr = adr_ff;
        nxt_exp = exp_ff;
        nxt_last = last_ff;
        nxt_prev = prev_ff;
        nxt_havep = havep_ff;
        nxt_quiet = quiet_ff;
        nxt_errseen = errseen_ff;
        nxt_busy = busy_ff;
        nxt_done = done_ff;
        nxt_fail = fail_ff;
        nxt_abort = abort_ff;
        nxt_ack = wb_req;
        nxt_rdat = rdat_ff;
        // Register writes
        if (wb_req && wb_we_i && !busy_ff) begin
            if (wb_adr_i == REG_ADDR) begin
                nxt_adr = wb_dat_i[25:0];
            end
            if (wb_adr_i == REG_DATA && wb_sel_i[0]) begin
                nxt_exp = wb_dat_i[7:0];
            end
        end
        // Register reads; unmapped reads return zero
        if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_ADDR: nxt_rdat = {6'h00, adr_ff};
                REG_DATA: nxt_rdat = {24'h000000, exp_ff};
                REG_STAT: nxt_rdat = {27'h0000000, rb_s2_ff, abort_ff,
                                      fail_ff, done_ff, busy_ff};
                REG_LAST: nxt_rdat = {16'h0000, last_ff};
                default: nxt_rdat = 32'h00000000;
            endcase
        end
        unique case (st_ff)
            ST_IDLE: begin
                if (wr_ctrl) begin
                    nxt_busy = 1'b1;
                    nxt_done = 1'b0;
                    nxt_fail = 1'b0;
                    nxt_abort = 1'b0;
                    nxt_havep = 1'b0;
                    nxt_quiet = 1'b0;
                    nxt_errseen = 1'b0;
                    nxt_step = 2'h0;
                    if (wb_dat_i[CTRL_RST3]) begin
                        nxt_mode = 2'h3;
                        nxt_st = ST_WR;
                    end else if (wb_dat_i[CTRL_RST1]) begin
                        nxt_mode = 2'h2;
                        nxt_st = ST_WR;
                    end else if (wb_dat_i[CTRL_TOGGLE]) begin
                        nxt_mode = 2'h1;
                        nxt_st = ST_RD;
                    end else if (wb_dat_i[CTRL_POLL]) begin
                        nxt_mode = 2'h0;
                        nxt_st = ST_RD;
                    end else begin
                        nxt_busy = 1'b0;
                    end
                    nxt_cnt = 4'h0;
                end
            end
            ST_RD: begin
                // Read cycle at the polling address
                nxt_pins.addr = adr_ff;
                nxt_pins.dq_oe = 1'b0;
                nxt_pins.ce_b = 1'b0;
                nxt_pins.oe_b = 1'b0;
                nxt_pins.we_b = 1'b1;
                if (cnt_ff == ACC_CNT + 4'h2) begin
                    nxt_st = ST_EVAL;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end
            ST_EVAL: begin
                nxt_pins.ce_b = 1'b1;
                nxt_pins.oe_b = 1'b1;
                nxt_last = {8'h00, sts};
                nxt_prev = dq_s2_ff;
                nxt_havep = 1'b1;
                nxt_st = ST_GAP;
                if (mode_ff == 2'h0) begin
                    // Polarity match means done
                    if (sts[COMPLETION_POLARITY_BIT] ==
                        exp_ff[COMPLETION_POLARITY_BIT]) begin
                        nxt_done = 1'b1;
                        nxt_st = ST_END;
                    end else if (sts[OPERATION_ERROR_BIT] ||
                                 sts[BUFFER_ABORT_BIT]) begin
                        if (errseen_ff) begin
                            // Re-read after error bit, as polarity may flip
                            nxt_fail = sts[OPERATION_ERROR_BIT];
                            nxt_abort = sts[BUFFER_ABORT_BIT];
                            nxt_st = ST_END;
                        end
                        nxt_errseen = 1'b1;
                    end
                end else begin
                    if (havep_ff && !toggled) begin
                        if (quiet_ff) begin
                            nxt_done = 1'b1;
                            nxt_st = ST_END;
                        end
                        nxt_quiet = 1'b1;
                    end else begin
                        nxt_quiet = 1'b0;
                        if (havep_ff && (sts[OPERATION_ERROR_BIT] ||
                                         sts[BUFFER_ABORT_BIT])) begin
                            if (errseen_ff) begin
                                nxt_fail = sts[OPERATION_ERROR_BIT];
                                nxt_abort = sts[BUFFER_ABORT_BIT];
                                nxt_st = ST_END;
                            end
                            nxt_errseen = 1'b1;
                        end
                    end
                end
            end
            ST_WR: begin
                // Write cycle of a reset command
                nxt_pins.ce_b = 1'b0;
                nxt_pins.oe_b = 1'b1;
                nxt_pins.dq_oe = 1'b1;
                if (mode_ff == 2'h3 && step_ff == 2'h0) begin
                    nxt_pins.addr = ADR_555;
                    nxt_pins.dq_out = CMD_AA;
                end else if (mode_ff == 2'h3 && step_ff == 2'h1) begin
                    nxt_pins.addr = ADR_2AA;
                    nxt_pins.dq_out = CMD_55;
                end else begin
                    nxt_pins.addr = adr_ff;
                    nxt_pins.dq_out = CMD_F0;
                end
                nxt_pins.we_b = (cnt_ff > WP_CNT);
                if (cnt_ff == WP_CNT + 4'h1) begin
                    nxt_cnt = 4'h0;
                    nxt_st = ST_NEXT;
                end else begin
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end
            ST_NEXT: begin
                nxt_pins.ce_b = 1'b1;
                nxt_pins.we_b = 1'b1;
                nxt_pins.dq_oe = 1'b0;
                if (mode_ff == 2'h3 && step_ff != 2'h2) begin
                    nxt_step = step_ff + 2'h1;
                    nxt_st = ST_WR;
                end else begin
                    nxt_done = 1'b1;
                    nxt_st = ST_END;
                end
            end
            ST_GAP: begin
                // Deselect between reads; pins stay released in this state and the first read cycle
                nxt_st = ST_RD;
            end
            ST_END: begin
                nxt_pins.ce_b = 1'b1;
                nxt_pins.oe_b = 1'b1;
                nxt_pins.we_b = 1'b1;
                nxt_pins.dq_oe = 1'b0;
                nxt_busy = 1'b0;
                nxt_st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= ST_IDLE;
            pins_ff <= '{addr: 26'h0000000, dq_out: 16'h0000, dq_oe: 1'b0,
                         ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
            cnt_ff <= 4'h0;
            step_ff <= 2'h0;
            mode_ff <= 2'h0;
            adr_ff <= 26'h0000000;
            exp_ff <= 8'h00;
            last_ff <= 16'h0000;
            prev_ff <= 16'h0000;
            havep_ff <= 1'b0;
            quiet_ff <= 1'b0;
            errseen_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
            abort_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
            pins_ff <= nxt_pins;
            cnt_ff <= nxt_cnt;
            step_ff <= nxt_step;
            mode_ff <= nxt_mode;
            adr_ff <= nxt_adr;
            exp_ff <= nxt_exp;
            last_ff <= nxt_last;
            prev_ff <= nxt_prev;
            havep_ff <= nxt_havep;
            quiet_ff <= nxt_quiet;
            errseen_ff <= nxt_errseen;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            fail_ff <= nxt_fail;
            abort_ff <= nxt_abort;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign pins_o = pins_ff;

endmodule

// *** tb/fosp_host_monitor.sv ***
// Checker of the polling host controller ports
`timescale 1ns/100ps
module fosp_host_monitor
    import fosp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire fosp_pins_t pins_o,
    input wire logic [15:0] dq_i,
    input wire logic busy_output_pin_i
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Flash read strobe and write pulse shapes
    sequence s_read_hold;
        (!pins_o.oe_b) [*6] ##1 pins_o.oe_b;
    endsequence
    sequence s_write_pulse;
        (!pins_o.we_b) [*2] ##1 pins_o.we_b;
    endsequence
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after a request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_read_hold: assert property ($fell(pins_o.oe_b) |-> s_read_hold)
        else $error("read strobe length wrong");
    a_write_pulse: assert property ($fell(pins_o.we_b) |-> s_write_pulse)
        else $error("write pulse length wrong");
    a_no_mixed: assert property (pins_o.oe_b || pins_o.we_b)
        else $error("read and write strobes together");
    a_no_fight: assert property (!pins_o.oe_b |-> !pins_o.dq_oe)
        else $error("data driven during a read");
    a_strobe_sel: assert property (!pins_o.oe_b || !pins_o.we_b |-> !pins_o.ce_b)
        else $error("strobe without chip enable");
    a_data_held: assert property ($rose(pins_o.we_b) |->
        pins_o.dq_oe && $stable(pins_o.dq_out))
        else $error("write data not held at latch");
endmodule

bind fosp_host fosp_host_monitor u_mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o),
    .dq_i(dq_i), .busy_output_pin_i(busy_output_pin_i));

// *** tb/fosp_flash_model.sv ***
// Behavioural flash that reports operation progress on reads
`timescale 1ns/100ps
module fosp_flash_model
    import fosp_pkg::*;
(
    input wire fosp_pins_t pins_i,
    input wire logic go_i,
    input wire logic [1:0] op_i,
    input wire logic [7:0] tgt_i,
    input wire logic [3:0] len_i,
    output logic [15:0] dq_o,
    output logic busy_b_o,
    output logic [23:0] wseq_o = 24'h000000,
    output logic [3:0] wn_o = 4'h0
);
    // Op 0 program, 1 erase, 2 failed program, 3 buffer abort
    logic [1:0] op = 2'd0;
    logic [7:0] tgt = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic tog = 1'b0;
    logic [15:0] held = 16'h0000;
    logic [15:0] drv;
    logic run;
    assign run = (op >= 2'd2) || (cnt != 4'h0);
    // Status byte while running, array data after success
    always_comb begin
        drv = 16'h0000;
        if (!run) begin
            drv = (op == 2'd1) ? 16'hffff : {8'h00, tgt};
        end else begin
            drv[7] = (op == 2'd1) ? 1'b0 : ~tgt[7];
            drv[6] = tog;
            drv[5] = (op == 2'd2);
            drv[3] = (op == 2'd1);
            drv[2] = (op == 2'd1) && tog;
            drv[1] = (op == 2'd3);
        end
    end
    // Selected: status or array data; released: inverse of last value
    assign dq_o = (!pins_i.ce_b && !pins_i.oe_b) ? drv : held;
    assign busy_b_o = !(run && op < 2'd2);
    // Status mode starts as soon as the operation is accepted
    always @(posedge go_i) begin
        op = op_i;
        tgt = tgt_i;
        cnt = len_i;
        tog = 1'b0;
        wn_o = 4'h0;
    end
    // End of each read access advances progress
    always @(posedge pins_i.oe_b) begin
        held = ~drv;
        if (run) tog = ~tog;
        if (cnt != 4'h0) cnt = cnt - 4'h1;
    end
    // Commands latch on the write strobe rising edge
    always @(posedge pins_i.we_b) begin
        if (!pins_i.ce_b) begin
            wseq_o = {wseq_o[15:0], pins_i.dq_out[7:0]};
            wn_o = wn_o + 4'h1;
            if (pins_i.dq_out[7:0] == 8'hf0 && (op == 2'd2 ||
                (op == 2'd3 && wseq_o[23:8] == 16'haa55))) begin
                op = 2'd0;
                cnt = 4'h0;
            end
        end
    end
endmodule

// *** tb/fosp_host_tb.sv ***
// Self-checking bench of the polling host controller
`timescale 1ns/100ps
module fosp_host_tb
    import fosp_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack;
    fosp_pins_t pins;
    logic [15:0] dq;
    logic busy_b;
    logic go = 1'b0;
    logic [1:0] op = 2'd0;
    logic [7:0] tgt = 8'h00;
    logic [3:0] len = 4'h0;
    logic [23:0] wseq;
    logic [3:0] wn;
    int err_total = 0;
    int comparisons = 0;
    always #25 mclk = ~mclk;
    fosp_host uut (.mclk_i(mclk), .rst_b_i(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .pins_o(pins),
        .dq_i(dq), .busy_output_pin_i(busy_b));
    fosp_flash_model flash (.pins_i(pins), .go_i(go), .op_i(op),
        .tgt_i(tgt), .len_i(len), .dq_o(dq), .busy_b_o(busy_b),
        .wseq_o(wseq), .wn_o(wn));
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wait_idle(output logic [31:0] s);
        s = 32'h1;
        for (int i = 0; i < 300 && s[STAT_BUSY] !== 1'b0; i++) begin
            wb(1'b0, REG_STAT, 32'h0, s);
        end
    endtask
    // Arm the flash operation, then order the controller
    task automatic start(input logic [1:0] o, input logic [7:0] t,
        input logic [3:0] n, input logic [31:0] c);
        logic [31:0] q;
        @(posedge mclk);
        op <= o;
        tgt <= t;
        len <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        wb(1'b1, REG_DATA, {24'h0, t}, q);
        wb(1'b1, REG_ADDR, 32'h100, q);
        wb(1'b1, REG_CTRL, c, q);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, REG_STAT, 32'h0, q);
        chk("idle status", 32'h10, q);
        wb(1'b0, REG_LAST, 32'h0, q);
        chk("last reset", 32'h0, q);
        wb(1'b1, 8'h14, 32'hffff, q);
        wb(1'b0, 8'h14, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic t_program();
        logic [31:0] q;
        start(2'd0, 8'h5a, 4'd3, 32'h1);
        wb(1'b0, REG_STAT, 32'h0, q);
        chk("busy pin low", 32'h1, q);
        wait_idle(q);
        chk("prog done", 32'h12, q);
        wb(1'b0, REG_LAST, 32'h0, q);
        chk("prog array", 32'h5a, q);
    endtask
    task automatic t_erase();
        logic [31:0] q;
        start(2'd1, 8'hff, 4'd4, 32'h2);
        wait_idle(q);
        chk("erase done", 32'h12, q);
        wb(1'b0, REG_LAST, 32'h0, q);
        chk("erase array", 32'hff, q);
    endtask
    task automatic t_fail(input logic [1:0] o, input logic [31:0] st,
        input logic [31:0] c, input logic [31:0] ws, input logic [31:0] n);
        logic [31:0] q;
        start(o, 8'h5a, 4'd1, 32'h1);
        wait_idle(q);
        chk("fail status", st, q);
        wb(1'b1, REG_CTRL, c, q);
        wait_idle(q);
        chk("reset writes", n, {28'h0, wn});
        chk("reset data", ws, {8'h0, wseq} & {8'h0, ws[23:0] | 24'hff});
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_program();
        t_erase();
        t_fail(2'd2, 32'h14, 32'h4, 32'hf0, 32'h1);
        t_fail(2'd3, 32'h18, 32'h8, 32'haa55f0, 32'h3);
        wrap_up();
    end
endmodule
